// *** include/dmac_pkg.sv ***
// ****************************************
// dma address control package
// ****************************************
package dmac_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int unsigned REG_ADDR_W = 8;
	localparam logic [7:0] OFF_ADDR_CTRL = 8'h00;
	localparam logic [7:0] OFF_CHAN_MODE = 8'h04;
	localparam logic [7:0] OFF_SRC_ADDR = 8'h08;
	localparam logic [7:0] OFF_DST_ADDR = 8'h0c;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;

	// ****************************************
	// address control fields
	// ****************************************
	localparam int unsigned MODE_SEL_BIT = 31;
	localparam int unsigned DIR_SEL_BIT = 30;
	localparam int unsigned RSV_HI = 29;
	localparam int unsigned RSV_LO = 27;
	localparam int unsigned END_IRQ_EN_BIT = 26;
	localparam int unsigned AREA_HI = 25;
	localparam int unsigned AREA_LO = 24;
	localparam int unsigned CTRL_BYTE = 3;
	localparam logic [1:0] AREA_SRC = 2'h0;
	localparam logic [1:0] AREA_DST = 2'h1;
	localparam logic [1:0] AREA_NONE = 2'h2;
	localparam logic [1:0] AREA_BAD = 2'h3;

	// ****************************************
	// channel mode fields
	// ****************************************
	localparam int unsigned XFER_EN_BIT = 0;
	localparam int unsigned END_FLAG_BIT = 1;
	localparam int unsigned ACKE_BIT = 2;
	localparam int unsigned XMODE_HI = 5;
	localparam int unsigned XMODE_LO = 4;
	localparam logic [1:0] XM_NORMAL = 2'h0;
	localparam logic [1:0] XM_REPEAT = 2'h1;
	localparam logic [1:0] XM_BLOCK = 2'h2;

	// ****************************************
	// interrupt status and misc
	// ****************************************
	localparam int unsigned IRQ_W = 2;
	localparam int unsigned IRQ_SIZE_END = 0;
	localparam int unsigned IRQ_BAD_AREA = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	typedef enum logic {
		UNIT_RUN,
		UNIT_DONE
	} dmac_unit_t;

endpackage

// *** design/dmac_sync2.sv ***
// ****************************************
// two flop synchroniser
// ****************************************
module dmac_sync2 #(
	parameter int W = 1
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] async_i,
	output logic [W-1:0] sync_o
);
	logic [W-1:0] meta;

	// first stage feeds only the second
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta <= '0;
			sync_o <= '0;
		end else begin
			meta <= async_i;
			sync_o <= meta;
		end
	end
endmodule // dmac_sync2

// *** design/dmac_axil_slave.sv ***
// ****************************************
// axi4-lite slave front end
// ****************************************
module dmac_axil_slave
	import dmac_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [dmac_pkg::REG_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [dmac_pkg::REG_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic wr_en_o,
	output logic [dmac_pkg::REG_ADDR_W-1:0] wr_addr_o,
	output logic [31:0] wr_data_o,
	output logic [3:0] wr_strb_o,
	input wire logic wr_ok_i,
	output logic [dmac_pkg::REG_ADDR_W-1:0] rd_addr_o,
	input wire logic [31:0] rd_data_i,
	input wire logic rd_ok_i
);
	logic aw_full, w_full, next_aw_full, next_w_full;
	logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0] next_bresp, next_rresp;
	logic [31:0] next_rdata, next_wdata;
	logic [3:0] next_wstrb;
	logic [REG_ADDR_W-1:0] next_awaddr;
	logic rd_en;

	// the write acts once both halves are held and no response is pending
	always_comb begin
		wr_en_o = aw_full && w_full && !s_axi_bvalid_o;
		rd_en = s_axi_arvalid_i && s_axi_arready_o;
		rd_addr_o = s_axi_araddr_i;
		next_awaddr = wr_addr_o;
		next_wdata = wr_data_o;
		next_wstrb = wr_strb_o;
		next_aw_full = aw_full;
		next_w_full = w_full;
		if (s_axi_awvalid_i && s_axi_awready_o) begin
			next_aw_full = 1'b1;
			next_awaddr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && s_axi_wready_o) begin
			next_w_full = 1'b1;
			next_wdata = s_axi_wdata_i;
			next_wstrb = s_axi_wstrb_i;
		end
		if (wr_en_o) begin
			next_aw_full = 1'b0;
			next_w_full = 1'b0;
		end
		next_bvalid = wr_en_o || (s_axi_bvalid_o && !s_axi_bready_i);
		next_bresp = wr_en_o ? (wr_ok_i ? RESP_OKAY : RESP_SLVERR) : s_axi_bresp_o;
		next_awready = !next_aw_full && !next_bvalid;
		next_wready = !next_w_full && !next_bvalid;
		next_rvalid = rd_en || (s_axi_rvalid_o && !s_axi_rready_i);
		next_rdata = rd_en ? rd_data_i : s_axi_rdata_o;
		next_rresp = rd_en ? (rd_ok_i ? RESP_OKAY : RESP_SLVERR) : s_axi_rresp_o;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_full <= 1'b0;
			w_full <= 1'b0;
			wr_addr_o <= '0;
			wr_data_o <= '0;
			wr_strb_o <= '0;
			s_axi_awready_o <= 1'b0;
			s_axi_wready_o <= 1'b0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= RESP_OKAY;
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= WORD_ZERO;
			s_axi_rresp_o <= RESP_OKAY;
		end else begin
			aw_full <= next_aw_full;
			w_full <= next_w_full;
			wr_addr_o <= next_awaddr;
			wr_data_o <= next_wdata;
			wr_strb_o <= next_wstrb;
			s_axi_awready_o <= next_awready;
			s_axi_wready_o <= next_wready;
			s_axi_bvalid_o <= next_bvalid;
			s_axi_bresp_o <= next_bresp;
			s_axi_arready_o <= next_arready;
			s_axi_rvalid_o <= next_rvalid;
			s_axi_rdata_o <= next_rdata;
			s_axi_rresp_o <= next_rresp;
		end
	end
endmodule // dmac_axil_slave

// *** design/dmac_addr_ctrl.sv ***
// Function
// R01: bit 31 picks dual or single addressing
// R02: single mode ack pin needs ack enable
// R03: bit 30 picks single mode direction
// R04: direction bit ignored in dual mode
// R05: bits 29 to 27 read zero
// R06: bit 26 enables size end interrupt
// R07: repeat unit done, next request stops
// R08: no-area code still allows end interrupt
// R09: block done, next request stops channel
// R10: bits 25:24 area select, 00 source
// R11: 01 destination, 10 none, 11 barred
// R12: end interrupt while flag and enable
module dmac_addr_ctrl
	import dmac_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic [dmac_pkg::REG_ADDR_W-1:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic [dmac_pkg::REG_ADDR_W-1:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic xfer_req_i,
	input wire logic unit_done_i,
	input wire logic ack_strobe_i,
	output logic xfer_go_o,
	output logic xfer_enable_o,
	output logic single_mode_o,
	output logic dir_dest_o,
	output logic [1:0] area_sel_o,
	output logic [31:0] single_addr_o,
	output logic transfer_ack_n_o,
	output logic end_irq_o,
	output logic irq_o
);
	// ****************************************
	// state
	// ****************************************
	logic single_sel, dir_sel, end_irq_en, xfer_en, end_flag, acke;
	logic [1:0] area, xmode;
	logic [31:0] src_addr, dst_addr;
	logic [IRQ_W-1:0] irq_stat, irq_mask;
	dmac_unit_t unit_state;
	logic req_prev, req_sync;

	logic next_single_sel, next_dir_sel, next_end_irq_en, next_xfer_en, next_end_flag, next_acke;
	logic [1:0] next_area, next_xmode;
	logic [31:0] next_src_addr, next_dst_addr;
	logic [IRQ_W-1:0] next_irq_stat, next_irq_mask, irq_set;
	dmac_unit_t next_unit_state;
	logic next_go, next_ack_n, next_end_irq, next_irq;
	logic [31:0] next_single_addr;

	logic wr_en, wr_ok, rd_ok, req_rise, stop_evt, bad_area;
	logic [REG_ADDR_W-1:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;

	// ****************************************
	// bus front end and pin synchroniser
	// ****************************************
	dmac_axil_slave u_bus (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.s_axi_awaddr_i(s_axi_awaddr_i),
		.s_axi_awvalid_i(s_axi_awvalid_i),
		.s_axi_awready_o(s_axi_awready_o),
		.s_axi_wdata_i(s_axi_wdata_i),
		.s_axi_wstrb_i(s_axi_wstrb_i),
		.s_axi_wvalid_i(s_axi_wvalid_i),
		.s_axi_wready_o(s_axi_wready_o),
		.s_axi_bresp_o(s_axi_bresp_o),
		.s_axi_bvalid_o(s_axi_bvalid_o),
		.s_axi_bready_i(s_axi_bready_i),
		.s_axi_araddr_i(s_axi_araddr_i),
		.s_axi_arvalid_i(s_axi_arvalid_i),
		.s_axi_arready_o(s_axi_arready_o),
		.s_axi_rdata_o(s_axi_rdata_o),
		.s_axi_rresp_o(s_axi_rresp_o),
		.s_axi_rvalid_o(s_axi_rvalid_o),
		.s_axi_rready_i(s_axi_rready_i),
		.wr_en_o(wr_en),
		.wr_addr_o(wr_addr),
		.wr_data_o(wr_data),
		.wr_strb_o(wr_strb),
		.wr_ok_i(wr_ok),
		.rd_addr_o(rd_addr),
		.rd_data_i(rd_data),
		.rd_ok_i(rd_ok)
	);

	// request arrives on a pin, so it is synchronised before edge detection
	dmac_sync2 #(.W(1)) u_req_sync (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.async_i(xfer_req_i),
		.sync_o(req_sync)
	);

	// ****************************************
	// address decode
	// ****************************************
	always_comb begin
		if (wr_addr == OFF_ADDR_CTRL || wr_addr == OFF_CHAN_MODE || wr_addr == OFF_SRC_ADDR) begin
			wr_ok = 1'b1;
		end else if (wr_addr == OFF_DST_ADDR || wr_addr == OFF_IRQ_STAT || wr_addr == OFF_IRQ_MASK) begin
			wr_ok = 1'b1;
		end else begin
			wr_ok = 1'b0;
		end
	end

	// lower address control bits are not implemented here and read zero
	always_comb begin
		rd_data = WORD_ZERO;
		rd_ok = 1'b1;
		if (rd_addr == OFF_ADDR_CTRL) begin
			rd_data[MODE_SEL_BIT] = single_sel;
			rd_data[DIR_SEL_BIT] = dir_sel;
			rd_data[END_IRQ_EN_BIT] = end_irq_en;
			rd_data[AREA_HI:AREA_LO] = area;
		end else if (rd_addr == OFF_CHAN_MODE) begin
			rd_data[XFER_EN_BIT] = xfer_en;
			rd_data[END_FLAG_BIT] = end_flag;
			rd_data[ACKE_BIT] = acke;
			rd_data[XMODE_HI:XMODE_LO] = xmode;
		end else if (rd_addr == OFF_SRC_ADDR) begin
			rd_data = src_addr;
		end else if (rd_addr == OFF_DST_ADDR) begin
			rd_data = dst_addr;
		end else if (rd_addr == OFF_IRQ_STAT) begin
			rd_data[IRQ_W-1:0] = irq_stat;
		end else if (rd_addr == OFF_IRQ_MASK) begin
			rd_data[IRQ_W-1:0] = irq_mask;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// ****************************************
	// unit tracking and stop
	// ****************************************
	always_comb begin
		req_rise = req_sync && !req_prev;
		next_unit_state = unit_state;
		stop_evt = 1'b0;
		next_go = 1'b0;
		case (unit_state)
			UNIT_RUN: begin
				if (xfer_en && unit_done_i && (xmode == XM_REPEAT || xmode == XM_BLOCK)) begin
					next_unit_state = UNIT_DONE;
				end
				next_go = xfer_en && req_rise; // R12
			end
			UNIT_DONE: begin
				if (!xfer_en) begin
					next_unit_state = UNIT_RUN;
				end else if (req_rise) begin
					next_unit_state = UNIT_RUN;
					// area code plays no part: no-area still stops // R08
					stop_evt = end_irq_en; // R07 R09
					next_go = !end_irq_en;
				end
			end
			default: next_unit_state = UNIT_RUN;
		endcase
	end

	// ****************************************
	// register writes
	// ****************************************
	always_comb begin
		next_single_sel = single_sel;
		next_dir_sel = dir_sel;
		next_end_irq_en = end_irq_en;
		next_area = area;
		next_xfer_en = xfer_en;
		next_end_flag = end_flag;
		next_acke = acke;
		next_xmode = xmode;
		next_src_addr = src_addr;
		next_dst_addr = dst_addr;
		next_irq_stat = irq_stat;
		next_irq_mask = irq_mask;
		bad_area = 1'b0;
		if (wr_en && wr_addr == OFF_ADDR_CTRL && wr_strb[CTRL_BYTE]) begin
			next_single_sel = wr_data[MODE_SEL_BIT]; // R01
			next_dir_sel = wr_data[DIR_SEL_BIT]; // R03
			next_end_irq_en = wr_data[END_IRQ_EN_BIT]; // R06
			// reserved bits 29:27 are dropped // R05
			// barred code keeps the old area so the sequencer never sees it
			if (wr_data[AREA_HI:AREA_LO] != AREA_BAD) begin
				next_area = wr_data[AREA_HI:AREA_LO]; // R10 R11
			end else begin
				bad_area = 1'b1; // R11
			end
		end else if (wr_en && wr_addr == OFF_CHAN_MODE && wr_strb[0]) begin
			next_xfer_en = wr_data[XFER_EN_BIT];
			next_end_flag = end_flag && wr_data[END_FLAG_BIT];
			next_acke = wr_data[ACKE_BIT];
			next_xmode = wr_data[XMODE_HI:XMODE_LO];
		end else if (wr_en && wr_addr == OFF_SRC_ADDR) begin
			for (int b = 0; b < 4; b++) begin
				if (wr_strb[b]) begin
					next_src_addr[b*8 +: 8] = wr_data[b*8 +: 8];
				end
			end
		end else if (wr_en && wr_addr == OFF_DST_ADDR) begin
			for (int b = 0; b < 4; b++) begin
				if (wr_strb[b]) begin
					next_dst_addr[b*8 +: 8] = wr_data[b*8 +: 8];
				end
			end
		end else if (wr_en && wr_addr == OFF_IRQ_STAT && wr_strb[0]) begin
			next_irq_stat = irq_stat & ~wr_data[IRQ_W-1:0];
		end else if (wr_en && wr_addr == OFF_IRQ_MASK && wr_strb[0]) begin
			next_irq_mask = wr_data[IRQ_W-1:0];
		end
		// hardware events come last so a set beats a same-cycle clear
		if (stop_evt) begin
			next_xfer_en = 1'b0; // R07 R09
			next_end_flag = 1'b1; // R07 R09
		end
		irq_set = '0;
		irq_set[IRQ_SIZE_END] = stop_evt;
		irq_set[IRQ_BAD_AREA] = bad_area;
		next_irq_stat = next_irq_stat | irq_set;
	end

	// ****************************************
	// registered outputs
	// ****************************************
	always_comb begin
		next_end_irq = next_end_flag && next_end_irq_en; // R06 R12
		next_irq = |(next_irq_stat & next_irq_mask);
		// ack pin is low active and only pulses when single mode and enabled
		next_ack_n = !(ack_strobe_i && single_sel && acke); // R02
		// single address bus uses source unless dest is chosen in single mode
		next_single_addr = (next_single_sel && next_dir_sel) ? next_dst_addr : next_src_addr; // R03 R04
	end

	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			single_sel <= 1'b0;
			dir_sel <= 1'b0;
			end_irq_en <= 1'b0;
			area <= AREA_SRC;
			xfer_en <= 1'b0;
			end_flag <= 1'b0;
			acke <= 1'b0;
			xmode <= XM_NORMAL;
			src_addr <= WORD_ZERO;
			dst_addr <= WORD_ZERO;
			irq_stat <= '0;
			irq_mask <= '0;
			unit_state <= UNIT_RUN;
			req_prev <= 1'b0;
			xfer_go_o <= 1'b0;
			xfer_enable_o <= 1'b0;
			single_mode_o <= 1'b0;
			dir_dest_o <= 1'b0;
			area_sel_o <= AREA_SRC;
			single_addr_o <= WORD_ZERO;
			transfer_ack_n_o <= 1'b1;
			end_irq_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			single_sel <= next_single_sel;
			dir_sel <= next_dir_sel;
			end_irq_en <= next_end_irq_en;
			area <= next_area;
			xfer_en <= next_xfer_en;
			end_flag <= next_end_flag;
			acke <= next_acke;
			xmode <= next_xmode;
			src_addr <= next_src_addr;
			dst_addr <= next_dst_addr;
			irq_stat <= next_irq_stat;
			irq_mask <= next_irq_mask;
			unit_state <= next_unit_state;
			req_prev <= req_sync;
			xfer_go_o <= next_go;
			xfer_enable_o <= next_xfer_en;
			single_mode_o <= next_single_sel;
			dir_dest_o <= next_single_sel && next_dir_sel;
			area_sel_o <= next_area;
			single_addr_o <= next_single_addr;
			transfer_ack_n_o <= next_ack_n;
			end_irq_o <= next_end_irq;
			irq_o <= next_irq;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	a_mode_write: assert property (@(posedge core_clk_i) disable iff (rst_i) // R01
		(wr_en && wr_addr == OFF_ADDR_CTRL && wr_strb[CTRL_BYTE]) |=> single_mode_o == $past(wr_data[MODE_SEL_BIT]))
		else $error("address mode not taken from write");
	a_ack_gated: assert property (@(posedge core_clk_i) disable iff (rst_i) // R02
		(ack_strobe_i && !(single_sel && acke)) |=> transfer_ack_n_o)
		else $error("ack pin driven while not permitted");
	a_dir_select: assert property (@(posedge core_clk_i) disable iff (rst_i) // R03
		(single_mode_o && dir_dest_o) |-> single_addr_o == dst_addr)
		else $error("single address not taken from destination");
	a_dual_nodir: assert property (@(posedge core_clk_i) disable iff (rst_i) // R04
		!single_mode_o |-> (!dir_dest_o && single_addr_o == src_addr))
		else $error("direction bit acted in dual mode");
	a_rsv_zero: assert property (@(posedge core_clk_i) disable iff (rst_i) // R05
		(s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i == OFF_ADDR_CTRL) |=> s_axi_rdata_o[RSV_HI:RSV_LO] == 3'h0)
		else $error("reserved bits read nonzero");
	a_irq_off: assert property (@(posedge core_clk_i) disable iff (rst_i) // R06
		(!end_irq_en && !next_end_irq_en) |=> !end_irq_o)
		else $error("end interrupt while disabled");
	a_stop_chan: assert property (@(posedge core_clk_i) disable iff (rst_i) // R07
		(unit_state == UNIT_DONE && xfer_en && end_irq_en && req_rise) |=>
		(!xfer_en && end_flag && !xfer_go_o) ##1 (end_irq_o || !end_irq_en))
		else $error("channel not stopped after unit end");
	a_noarea_stop: assert property (@(posedge core_clk_i) disable iff (rst_i) // R08
		(area == AREA_NONE && stop_evt) |=> end_flag && irq_stat[IRQ_SIZE_END])
		else $error("no-area mode missed end interrupt");
	a_block_stop: assert property (@(posedge core_clk_i) disable iff (rst_i) // R09
		(xmode == XM_BLOCK && xfer_en && unit_done_i && unit_state == UNIT_RUN) |=> unit_state == UNIT_DONE)
		else $error("block end not recorded");
	a_area_legal: assert property (@(posedge core_clk_i) disable iff (rst_i) // R10 R11
		area != AREA_BAD && area_sel_o != AREA_BAD)
		else $error("barred area code stored");
	a_halt_off: assert property (@(posedge core_clk_i) disable iff (rst_i) // R12
		!xfer_en |=> !xfer_go_o)
		else $error("transfer started while disabled");
endmodule // dmac_addr_ctrl

// *** bench/dmac_seq_model.sv ***
// ****************************************
// transfer sequencer model
// ****************************************
module dmac_seq_model (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic go_i,
	input wire logic slow_i,
	output logic ack_strobe_o,
	output logic unit_done_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] cnt;
	// one ack strobe, then one unit done per accepted request; slow mode delays the strobe by three cycles
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt <= 3'h0;
			ack_strobe_o <= 1'b0;
			unit_done_o <= 1'b0;
		end else begin
			if (go_i) begin
				cnt <= slow_i ? 3'h4 : 3'h1;
			end else if (cnt != 3'h0) begin
				cnt <= cnt - 3'h1;
			end
			ack_strobe_o <= (cnt == 3'h1) && !go_i;
			unit_done_o <= ack_strobe_o;
		end
	end
endmodule // dmac_seq_model

// *** bench/tb_top.sv ***
module tb_top import dmac_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, sa;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, req = 1'b0, slow = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, go, en, sm, dd, ackn, eirq, irq, ack_s, done;
	logic [1:0] bresp, rresp, area;
	int n_errors = 0;
	int comparisons = 0;
	int g, l;

	dmac_addr_ctrl uut (.core_clk_i(clk), .rst_i(rst),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
		.s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
		.s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
		.s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
		.xfer_req_i(req), .unit_done_i(done), .ack_strobe_i(ack_s), .xfer_go_o(go), .xfer_enable_o(en),
		.single_mode_o(sm), .dir_dest_o(dd), .area_sel_o(area), .single_addr_o(sa),
		.transfer_ack_n_o(ackn), .end_irq_o(eirq), .irq_o(irq));

	dmac_seq_model seq (.core_clk_i(clk), .rst_i(rst), .go_i(go), .slow_i(slow),
		.ack_strobe_o(ack_s), .unit_done_o(done));

	initial begin
		forever #20 clk = ~clk;
	end

	// ****************************************
	// common tasks
	// ****************************************
	task automatic test_done;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic hang;
		n_errors++;
		test_done();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int i;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		if (i == 40) hang();
		chk(32'(bresp), 32'(er));
		bready <= 1'b0;
		// registered outputs load from the next values on the same edge as the register write
		repeat (2) @(posedge clk);
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		int i;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (i = 0; i < 40; i++) begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		if (i == 40) hang();
		chk(rdata, ed);
		chk(32'(rresp), 32'(er));
		rready <= 1'b0;
	endtask

	// request pin held a few cycles; counts go pulses and ack-low cycles seen
	task automatic pulse(output int gn, output int ln);
		int i;
		gn = 0;
		ln = 0;
		req <= 1'b1;
		for (i = 0; i < 24; i++) begin
			@(posedge clk);
			if (i == 3) req <= 1'b0;
			if (go === 1'b1) gn++;
			if (ackn === 1'b0) ln++;
		end
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task automatic t_reset;
		rchk(OFF_ADDR_CTRL, 32'h0, RESP_OKAY);
		rchk(OFF_CHAN_MODE, 32'h0, RESP_OKAY);
		chk(32'(ackn), 32'h1);
		chk(32'(irq), 32'h0);
		$display("test reset done");
	endtask

	task automatic t_fields;
		wr(OFF_ADDR_CTRL, 32'hfd00_ffff, RESP_OKAY);
		rchk(OFF_ADDR_CTRL, 32'hc500_0000, RESP_OKAY);
		chk(32'({sm, dd, area}), 32'hd);
		wr(OFF_ADDR_CTRL, 32'h4200_0000, RESP_OKAY);
		chk(32'({sm, dd, area}), 32'h2);
		wr(OFF_ADDR_CTRL, 32'h0000_0000, RESP_OKAY);
		chk(32'(area), 32'h0);
		// barred area code: old area kept, other fields still taken, status bit raised
		wr(OFF_ADDR_CTRL, 32'h4300_0000, RESP_OKAY);
		rchk(OFF_ADDR_CTRL, 32'h4000_0000, RESP_OKAY);
		rchk(OFF_IRQ_STAT, 32'h2, RESP_OKAY);
		chk(32'(irq), 32'h0);
		wr(OFF_IRQ_MASK, 32'h2, RESP_OKAY);
		chk(32'(irq), 32'h1);
		wr(OFF_IRQ_STAT, 32'h2, RESP_OKAY);
		chk(32'(irq), 32'h0);
		wr(OFF_IRQ_MASK, 32'h1, RESP_OKAY);
		wr(OFF_SRC_ADDR, 32'h1111_2222, RESP_OKAY);
		wr(OFF_DST_ADDR, 32'h3333_4444, RESP_OKAY);
		wr(OFF_ADDR_CTRL, 32'h8000_0000, RESP_OKAY);
		chk(sa, 32'h1111_2222);
		wr(OFF_ADDR_CTRL, 32'hc000_0000, RESP_OKAY);
		chk(sa, 32'h3333_4444);
		wr(8'h20, 32'h1, RESP_SLVERR);
		rchk(8'h20, 32'h0, RESP_SLVERR);
		$display("test fields done");
	endtask

	task automatic t_ack(input logic [31:0] ctrl, input logic [31:0] mode, input int exp_low);
		wr(OFF_ADDR_CTRL, ctrl, RESP_OKAY);
		wr(OFF_CHAN_MODE, mode, RESP_OKAY);
		pulse(g, l);
		chk(32'(g), 32'h1);
		chk(32'(l), 32'(exp_low));
		$display("test ack done");
	endtask

	task automatic t_stop(input logic [31:0] ctrl, input logic [31:0] mode, input logic stop);
		// dropping the enable clears a stop left armed by the previous test's last unit
		wr(OFF_CHAN_MODE, 32'h0, RESP_OKAY);
		wr(OFF_ADDR_CTRL, ctrl, RESP_OKAY);
		wr(OFF_CHAN_MODE, mode, RESP_OKAY);
		pulse(g, l);
		chk(32'(g), 32'h1);
		pulse(g, l);
		chk(32'(g), 32'(!stop));
		chk(32'(en), 32'(!stop));
		chk(32'(eirq), 32'(stop));
		chk(32'(irq), 32'(stop));
		rchk(OFF_CHAN_MODE, stop ? ((mode & 32'hffff_fffe) | 32'h2) : mode, RESP_OKAY);
		rchk(OFF_IRQ_STAT, 32'(stop), RESP_OKAY);
		wr(OFF_IRQ_STAT, 32'h1, RESP_OKAY);
		pulse(g, l);
		chk(32'(g), 32'(!stop));
		wr(OFF_CHAN_MODE, mode, RESP_OKAY);
		chk(32'(eirq), 32'h0);
		pulse(g, l);
		chk(32'(g), 32'h1);
		$display("test stop done");
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_fields();
		t_ack(32'h8000_0000, 32'h5, 1);
		slow <= 1'b1;
		t_ack(32'h8000_0000, 32'h1, 0);
		t_ack(32'h0000_0000, 32'h5, 0);
		slow <= 1'b0;
		t_stop(32'h0400_0000, 32'h11, 1'b1);
		t_stop(32'h0600_0000, 32'h21, 1'b1);
		t_stop(32'h0000_0000, 32'h11, 1'b0);
		test_done();
	end
endmodule // tb_top
